// >>> core/frm_core.sv
// Execute logic for or/copy/store file register instructions
`default_nettype none
module frm_core #(
  parameter int NUM_REGS = frm_pkg::NUM_REGS
) (
  input  wire logic        clock_i,
  input  wire logic        rstn_i,
  input  wire logic        insn_valid_i,
  input  wire logic [11:0] insn_i,
  output var  logic [7:0]  acc_o,
  output var  logic        zero_o,
  output var  logic        file_we_o,
  output var  logic [4:0]  file_addr_o,
  output var  logic [7:0]  file_data_o
);
  //--------------------------------------------------------------
  // Decode
  //--------------------------------------------------------------
  frm_pkg::frm_op_e op;
  logic             dest;
  logic [4:0]       addr;

  frm_decode u_dec (
    .insn_i (insn_i),
    .op_o   (op),
    .dest_o (dest),
    .addr_o (addr)
  );

  //--------------------------------------------------------------
  // State
  //--------------------------------------------------------------
  logic [7:0] regs_ff [NUM_REGS];
  logic [7:0] nxt_regs [NUM_REGS];
  logic [7:0] acc_ff;
  logic [7:0] nxt_acc;
  logic       zero_ff;
  logic       nxt_zero;
  logic       we_ff;
  logic       nxt_we;
  logic [4:0] waddr_ff;
  logic [4:0] nxt_waddr;
  logic [7:0] wdata_ff;
  logic [7:0] nxt_wdata;
  logic [7:0] fval;
  logic [7:0] res;

  // Full 5-bit address reaches all 32 registers
  assign fval = regs_ff[addr];

  //--------------------------------------------------------------
  // Next-state logic
  //--------------------------------------------------------------
  always_comb begin
    nxt_acc   = acc_ff;
    nxt_zero  = zero_ff;
    nxt_we    = 1'b0;
    nxt_waddr = waddr_ff;
    nxt_wdata = wdata_ff;
    res       = frm_pkg::ZERO_BYTE;
    for (int i = 0; i < NUM_REGS; i++) begin
      nxt_regs[i] = regs_ff[i];
    end
    if (insn_valid_i) begin
      unique case (op)
        frm_pkg::FRM_OP_OR:    res = acc_ff | fval;
        frm_pkg::FRM_OP_COPY:  res = fval;
        frm_pkg::FRM_OP_STORE: res = acc_ff;
        frm_pkg::FRM_OP_NONE:  res = frm_pkg::ZERO_BYTE;
      endcase
      if (op != frm_pkg::FRM_OP_NONE) begin
        if (dest == frm_pkg::DEST_ACC) begin
          nxt_acc = res;
        end else begin
          nxt_regs[addr] = res;
          nxt_we         = 1'b1;
          nxt_waddr      = addr;
          nxt_wdata      = res;
        end
      end
      // Store leaves the zero flag alone
      if (op == frm_pkg::FRM_OP_OR || op == frm_pkg::FRM_OP_COPY) begin
        nxt_zero = (res == frm_pkg::ZERO_BYTE);
      end
    end
  end

  //--------------------------------------------------------------
  // Registers
  //--------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      acc_ff   <= frm_pkg::ACC_RST;
      zero_ff  <= 1'b0;
      we_ff    <= 1'b0;
      waddr_ff <= '0;
      wdata_ff <= frm_pkg::ZERO_BYTE;
    end else begin
      acc_ff   <= nxt_acc;
      zero_ff  <= nxt_zero;
      we_ff    <= nxt_we;
      waddr_ff <= nxt_waddr;
      wdata_ff <= nxt_wdata;
    end
  end

  //--------------------------------------------------------------
  // File register array
  //--------------------------------------------------------------
  // Each entry resets to its own index so data paths carry values
  for (genvar gi = 0; gi < NUM_REGS; gi++) begin : g_file
    always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
        regs_ff[gi] <= frm_pkg::REG_RST | 8'(gi);
      end else begin
        regs_ff[gi] <= nxt_regs[gi];
      end
    end
  end

  //--------------------------------------------------------------
  // Outputs
  //--------------------------------------------------------------
  assign acc_o       = acc_ff;
  assign zero_o      = zero_ff;
  assign file_we_o   = we_ff;
  assign file_addr_o = waddr_ff;
  assign file_data_o = wdata_ff;

  //--------------------------------------------------------------
  // Assertions
  //--------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);

  property p_or_acc;
    insn_valid_i && op == frm_pkg::FRM_OP_OR && !dest |=>
      acc_o == ($past(acc_ff) | $past(fval)) && !file_we_o;
  endproperty
  a_or_acc: assert property (p_or_acc) else $error("or to acc wrong");

  property p_or_file;
    insn_valid_i && op == frm_pkg::FRM_OP_OR && dest |=>
      file_we_o && file_addr_o == $past(addr) && file_data_o == ($past(acc_ff) | $past(fval))
      && acc_o == $past(acc_ff);
  endproperty
  a_or_file: assert property (p_or_file) else $error("or to file wrong");

  property p_or_zero;
    insn_valid_i && op == frm_pkg::FRM_OP_OR |=>
      zero_o == (($past(acc_ff) | $past(fval)) == frm_pkg::ZERO_BYTE);
  endproperty
  a_or_zero: assert property (p_or_zero) else $error("or zero flag wrong");

  // Write mirror agrees with the array entry
  property p_addr_hit;
    file_we_o |->
      regs_ff[file_addr_o] == file_data_o;
  endproperty
  a_addr_hit: assert property (p_addr_hit) else $error("file write lost");

  property p_copy_acc;
    insn_valid_i && op == frm_pkg::FRM_OP_COPY && !dest |=>
      acc_o == $past(fval) && !file_we_o
      && zero_o == ($past(fval) == frm_pkg::ZERO_BYTE);
  endproperty
  a_copy_acc: assert property (p_copy_acc) else $error("copy to acc wrong");

  property p_copy_file;
    insn_valid_i && op == frm_pkg::FRM_OP_COPY && dest |=>
      file_we_o && file_addr_o == $past(addr) && file_data_o == $past(fval)
      && $stable(acc_o) && zero_o == ($past(fval) == frm_pkg::ZERO_BYTE);
  endproperty
  a_copy_file: assert property (p_copy_file) else $error("copy to file wrong");

  property p_store;
    insn_valid_i && op == frm_pkg::FRM_OP_STORE |=>
      file_we_o && file_addr_o == $past(addr) && file_data_o == $past(acc_ff)
      && $stable(zero_o) && $stable(acc_o);
  endproperty
  a_store: assert property (p_store) else $error("store wrong");

  // Refused words leave everything alone
  property p_idle;
    !insn_valid_i || op == frm_pkg::FRM_OP_NONE |=>
      !file_we_o && $stable(acc_o) && $stable(zero_o);
  endproperty
  a_idle: assert property (p_idle) else $error("state changed without op");

  // Flags and accumulator move only when an op says so
  property p_zero_hold;
    !(insn_valid_i && (op == frm_pkg::FRM_OP_OR || op == frm_pkg::FRM_OP_COPY)) |=>
      $stable(zero_o);
  endproperty
  a_zero_hold: assert property (p_zero_hold) else $error("zero flag moved");

  property p_acc_hold;
    !(insn_valid_i && op != frm_pkg::FRM_OP_NONE && dest == frm_pkg::DEST_ACC) |=>
      $stable(acc_o);
  endproperty
  a_acc_hold: assert property (p_acc_hold) else $error("acc moved");

  property p_we_source;
    file_we_o |->
      $past(insn_valid_i) && $past(op) != frm_pkg::FRM_OP_NONE && $past(dest);
  endproperty
  a_we_source: assert property (p_we_source) else $error("stray file write");

  //--------------------------------------------------------------
  // Coverage
  //--------------------------------------------------------------
  c_or_zero: cover property (insn_valid_i && op == frm_pkg::FRM_OP_OR ##1 zero_o);
  c_copy_f: cover property (insn_valid_i && op == frm_pkg::FRM_OP_COPY && dest);
  c_store: cover property (insn_valid_i && op == frm_pkg::FRM_OP_STORE ##1 file_we_o);
  c_or_acc: cover property (insn_valid_i && op == frm_pkg::FRM_OP_OR && !dest ##1 !zero_o);
  c_copy_zero: cover property (insn_valid_i && op == frm_pkg::FRM_OP_COPY && !dest ##1 zero_o);
endmodule
`default_nettype wire

// >>> core/frm_pkg.sv
// Package: encodings and widths for the file register move/or decoder
`default_nettype none
package frm_pkg;
  localparam int INSN_W      = 12;
  localparam int DATA_W      = 8;
  localparam int ADDR_W      = 5;
  localparam int NUM_REGS    = 32;
  // Opcode fields
  localparam int OP6_MSB     = 11;
  localparam int OP6_LSB     = 6;
  localparam int OP7_LSB     = 5;
  localparam int DEST_BIT    = 5;
  localparam logic [5:0] OP_OR_FILE   = 6'h04;
  localparam logic [5:0] OP_COPY_FILE = 6'h08;
  localparam logic [6:0] OP_STORE_ACC = 7'h01;
  localparam logic       DEST_ACC     = 1'b0;
  localparam logic       DEST_FILE    = 1'b1;
  // Reset values
  localparam logic [7:0] ACC_RST   = 8'h00;
  localparam logic [7:0] REG_RST   = 8'h00;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  typedef enum logic [1:0] {
    FRM_OP_NONE,
    FRM_OP_OR,
    FRM_OP_COPY,
    FRM_OP_STORE
  } frm_op_e;
endpackage
`default_nettype wire

// >>> core/frm_decode.sv
// Combinational instruction field decoder
`default_nettype none
module frm_decode (
  input  wire logic [11:0]       insn_i,
  output var  frm_pkg::frm_op_e  op_o,
  output var  logic              dest_o,
  output var  logic [4:0]        addr_o
);
  always_comb begin
    op_o   = frm_pkg::FRM_OP_NONE;
    dest_o = insn_i[frm_pkg::DEST_BIT];
    addr_o = insn_i[frm_pkg::ADDR_W-1:0];
    if (insn_i[frm_pkg::OP6_MSB:frm_pkg::OP6_LSB] == frm_pkg::OP_OR_FILE) begin
      op_o = frm_pkg::FRM_OP_OR;
    end else if (insn_i[frm_pkg::OP6_MSB:frm_pkg::OP6_LSB] == frm_pkg::OP_COPY_FILE) begin
      op_o = frm_pkg::FRM_OP_COPY;
    end else if (insn_i[frm_pkg::OP6_MSB:frm_pkg::OP7_LSB] == frm_pkg::OP_STORE_ACC) begin
      op_o   = frm_pkg::FRM_OP_STORE;
      dest_o = frm_pkg::DEST_FILE;
    end
  end
endmodule
`default_nettype wire

// >>> bench/test_file_register_move_or_ops.sv
// Self-checking bench for the or/copy/store execute block
`default_nettype none
module test_file_register_move_or_ops;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock_i;
  logic        rstn_i;
  logic        insn_valid_i;
  logic [11:0] insn_i;
  logic [7:0]  acc_o;
  logic        zero_o;
  logic        file_we_o;
  logic [4:0]  file_addr_o;
  logic [7:0]  file_data_o;
  int          miscompares;
  int          check_count;
  int          cycles;

  frm_core dut_u (
    .clock_i     (clock_i),
    .rstn_i      (rstn_i),
    .insn_valid_i(insn_valid_i),
    .insn_i      (insn_i),
    .acc_o       (acc_o),
    .zero_o      (zero_o),
    .file_we_o   (file_we_o),
    .file_addr_o (file_addr_o),
    .file_data_o (file_data_o)
  );

  // ------------------------------------------------------------
  // Clock, watchdog, shared tasks
  // ------------------------------------------------------------
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end

  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (cycles == 500) begin
      miscompares++;
      report_and_stop();
    end
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One instruction, then outputs sampled just after the taking edge
  task automatic run(input logic valid, input logic [11:0] word);
    @(posedge clock_i);
    insn_valid_i <= valid;
    insn_i       <= word;
    @(posedge clock_i);
    insn_valid_i <= 1'b0;
    #1;
  endtask

  // Two instructions on back-to-back edges, outputs sampled after the second
  task automatic run_pair(input logic [11:0] first, input logic [11:0] second);
    @(posedge clock_i);
    insn_valid_i <= 1'b1;
    insn_i       <= first;
    @(posedge clock_i);
    insn_i       <= second;
    @(posedge clock_i);
    insn_valid_i <= 1'b0;
    #1;
  endtask

  // First store writes the reset accumulator into file register 0x11
  task automatic store_first;
    run(1'b1, 12'h031);
    check("we", 8'(file_we_o), 8'h01);
    check("addr", 8'(file_addr_o), 8'h11);
    check("data", file_data_o, 8'h00);
    check("zero", 8'(zero_o), 8'h00);
  endtask

  task automatic or_to_file_top;
    run(1'b1, 12'h100);
    check("zero", 8'(zero_o), 8'h01);
    check("acc", acc_o, 8'h00);
    run(1'b1, 12'h13F);
    check("we", 8'(file_we_o), 8'h01);
    check("addr", 8'(file_addr_o), 8'h1F);
    check("data", file_data_o, 8'h1F);
    check("zero", 8'(zero_o), 8'h00);
  endtask

  task automatic copy_both_dests;
    run(1'b1, 12'h205);
    check("we", 8'(file_we_o), 8'h00);
    check("acc", acc_o, 8'h05);
    run(1'b1, 12'h225);
    check("we", 8'(file_we_o), 8'h01);
    check("addr", 8'(file_addr_o), 8'h05);
    check("data", file_data_o, 8'h05);
    check("zero", 8'(zero_o), 8'h00);
  endtask

  task automatic ignored_words;
    run(1'b0, 12'h031);
    check("we", 8'(file_we_o), 8'h00);
    run(1'b1, 12'hFFF);
    check("we", 8'(file_we_o), 8'h00);
    check("addr", 8'(file_addr_o), 8'h05);
    check("acc", acc_o, 8'h05);
  endtask

  // Zero flag both ways, then a read right behind a write
  task automatic zero_and_forward;
    run(1'b1, 12'h211);
    check("acc", acc_o, 8'h00);
    check("zero", 8'(zero_o), 8'h01);
    run(1'b1, 12'h10A);
    check("acc", acc_o, 8'h0A);
    check("zero", 8'(zero_o), 8'h00);
    check("we", 8'(file_we_o), 8'h00);
    run_pair(12'h02C, 12'h20C);
    check("acc", acc_o, 8'h0A);
    check("we", 8'(file_we_o), 8'h00);
    check("data", file_data_o, 8'h0A);
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    miscompares = 0;
    check_count = 0;
    cycles = 0;
    rstn_i = 1'b0;
    insn_valid_i = 1'b0;
    insn_i = 12'h000;
    repeat (3) @(posedge clock_i);
    rstn_i <= 1'b1;
    #1;
    check("acc", acc_o, 8'h00);
    check("zero", 8'(zero_o), 8'h00);
    store_first();
    or_to_file_top();
    copy_both_dests();
    ignored_words();
    zero_and_forward();
    report_and_stop();
  end
endmodule
`default_nettype wire
